// >>> verif/ssee_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none

// pin-level watch of the serial slave output behaviour
module ssee_chk #(
   parameter integer WC_CYCLES = 200
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic hold_n,
   input  wire logic wp_n,
   input  wire logic so_out,
   input  wire logic so_oe
);
   logic       sck_d_reg;
   logic [3:0] rise_cnt_reg;

   // count raw clock rises since select went low, saturating
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sck_d_reg    <= 1'b0;
         rise_cnt_reg <= 4'h0;
      end else begin
         sck_d_reg <= sck;
         if (cs_n)
            rise_cnt_reg <= 4'h0;
         else if (sck && !sck_d_reg && rise_cnt_reg != 4'hF)
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // quiet spans long enough for the synchronisers to settle
   sequence s_desel_idle;
      cs_n [*6];
   endsequence
   sequence s_paused;
      !hold_n [*6];
   endsequence
   sequence s_clk_high;
      (sck && !cs_n) [*6];
   endsequence

   // output enable and output data timing
   a_desel_float: assert property (s_desel_idle |-> !so_oe)
      else $error("output driven while deselected");
   a_desel_drop: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
      else $error("output not released after deselect");
   a_hold_float: assert property (s_paused |-> !so_oe)
      else $error("output driven while paused");
   a_hold_drop: assert property ($fell(hold_n) |-> ##[1:6] !so_oe)
      else $error("output not released after pause");
   a_oe_start: assert property ($rose(so_oe) |-> !cs_n && hold_n && !sck)
      else $error("output enabled outside a low clock phase");
   a_oe_late: assert property ($rose(so_oe) |-> rise_cnt_reg >= 4'h8)
      else $error("output enabled before a full opcode");
   a_out_low_phase: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !sck)
      else $error("output data changed in high clock phase");
   a_out_steady: assert property (s_clk_high |-> $stable(so_out))
      else $error("output data moved while clock high");
endmodule // ssee_chk

bind ssee_top ssee_chk #(.WC_CYCLES(WC_CYCLES)) u_ssee_chk (
   .sys_clk(sys_clk),
   .nrst   (nrst),
   .cs_n   (cs_n),
   .sck    (sck),
   .si     (si),
   .hold_n (hold_n),
   .wp_n   (wp_n),
   .so_out (so_out),
   .so_oe  (so_oe)
);

`default_nettype wire

// >>> verif/ssee_host.sv
`timescale 1ns/100ps
`default_nettype none

// serial link master model, paced by sys_clk
module ssee_host (
   input  wire logic sys_clk,
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   output logic      hold_n,
   input  wire logic so_out,
   input  wire logic so_oe
);
   logic [7:0] tx [0:15];
   logic [7:0] rx [0:15];
   logic       oe_seen;

   // idle levels at time zero
   initial begin
      cs_n    = 1'b1;
      sck     = 1'b0;
      si      = 1'b0;
      hold_n  = 1'b1;
      oe_seen = 1'b0;
   end

   // one framed transfer of n bytes, optional pause before bit hb
   task xfer(input int n, input int hb);
      int b;
      oe_seen = 1'b0;
      @(posedge sys_clk) cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (b = 0; b < n * 8; b++) begin
         si <= tx[b / 8][7 - b % 8];
         repeat (6) @(posedge sys_clk);
         if (b == hb) begin
            hold_n <= 1'b0;
            repeat (20) @(posedge sys_clk);
            hold_n <= 1'b1;
            repeat (6) @(posedge sys_clk);
         end
         // an undriven line reads as the inverse, so a dropped enable shows up
         rx[b / 8][7 - b % 8] = so_oe ? so_out : ~so_out;
         oe_seen = oe_seen | so_oe;
         sck <= 1'b1;
         repeat (6 + b % 2) @(posedge sys_clk);
         sck <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      cs_n <= 1'b1;
      si   <= ~si;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // ssee_host

`default_nettype wire

// >>> verif/ssee_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module ssee_top_bench;
   logic sys_clk;
   logic nrst;
   logic wp_n;
   wire  cs_n, sck, si, hold_n, so_out, so_oe;
   int   n_fail;
   int   comparisons;

   ssee_top #(.WC_CYCLES(400)) u_ssee_top (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n),
      .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe));
   ssee_host u_ssee_host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));

   ////////////////////////////////////////////////////////////////////////
   // common helpers
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task go(input logic [7:0] b0, input logic [7:0] b1, input int n, input int hb);
      u_ssee_host.tx[0] = b0;
      u_ssee_host.tx[1] = b1;
      u_ssee_host.xfer(n, hb);
   endtask
   task status(input logic [7:0] exp);
      go(8'h05, 8'h00, 2, -1);
      chk(u_ssee_host.rx[1], exp);
   endtask
   task wait_ready;
      int k;
      u_ssee_host.rx[1] = 8'hFF;
      for (k = 0; k < 20 && u_ssee_host.rx[1][0] !== 1'b0; k++)
         go(8'h05, 8'h00, 2, -1);
      go(8'h05, 8'h00, 2, -1);
      chk(u_ssee_host.rx[1] & 8'hF1, 8'h00);
   endtask
   task wr1(input logic [8:0] a, input logic [7:0] d);
      go(8'h06, 8'h00, 1, -1);
      u_ssee_host.tx[2] = d;
      go({4'h0, a[8], 3'b010}, a[7:0], 3, -1);
      wait_ready;
   endtask
   task rd(input logic [8:0] a, input int n, input int hb);
      go({4'h0, a[8], 3'b011}, a[7:0], 2 + n, hb);
   endtask
   task set_lvl(input logic [1:0] l);
      go(8'h06, 8'h00, 1, -1);
      go(8'h01, {4'h0, l, 2'b00}, 2, -1);
      wait_ready;
      status({4'h0, l, 2'b00});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_power_up;
      int i;
      status(8'h00);
      for (i = 0; i < 2; i++) begin
         u_ssee_host.tx[2] = 8'h05;
         go(i ? 8'h07 : 8'h83, 8'h03, 3, -1);
         chk({7'h0, u_ssee_host.oe_seen}, 8'h00);
      end
   endtask
   task t_latch;
      go(8'h0E, 8'h00, 1, -1);
      status(8'h02);
      @(posedge sys_clk) wp_n <= 1'b0;
      go(8'h0C, 8'h00, 1, -1);
      status(8'h00);
      go(8'h06, 8'h00, 1, -1);
      status(8'h00);
      @(posedge sys_clk) wp_n <= 1'b1;
   endtask
   task t_page;
      int i;
      go(8'h06, 8'h00, 1, -1);
      for (i = 0; i < 10; i++)
         u_ssee_host.tx[2 + i] = 8'hA0 + 8'(i);
      go(8'h0A, 8'hFE, 12, -1);
      status(8'hFF);
      rd(9'h1F8, 1, -1);
      chk({7'h0, u_ssee_host.oe_seen}, 8'h00);
      wait_ready;
      status(8'h00);
      wr1(9'h000, 8'h5C);
      rd(9'h1F8, 9, 20);
      for (i = 0; i < 9; i++)
         chk(u_ssee_host.rx[2 + i], i < 8 ? 8'hA2 + 8'(i) : 8'h5C);
   endtask
   task t_protect;
      int k;
      logic [8:0] b;
      for (k = 1; k < 4; k++) begin
         b = (k == 1) ? 9'h180 : (k == 2) ? 9'h100 : 9'h000;
         wr1(b, 8'h60 + 8'(k));
         set_lvl(2'(k));
         wr1(b, 8'hC0);
         wr1(b - 9'h001, 8'hC0);
         rd(b - 9'h001, 2, -1);
         chk(u_ssee_host.rx[2], k < 3 ? 8'hC0 : 8'hA9);
         chk(u_ssee_host.rx[3], 8'h60 + 8'(k));
      end
      set_lvl(2'h0);
   endtask
   task t_wp_drop;
      go(8'h06, 8'h00, 1, -1);
      u_ssee_host.tx[2] = 8'h11;
      fork
         go(8'h0A, 8'hFF, 3, -1);
         begin
            repeat (250) @(posedge sys_clk);
            wp_n <= 1'b0;
            repeat (25) @(posedge sys_clk);
            wp_n <= 1'b1;
         end
      join
      @(posedge sys_clk) wp_n <= 1'b1;
      rd(9'h1FF, 1, -1);
      chk(u_ssee_host.rx[2], 8'hA9);
      go(8'h04, 8'h00, 1, -1);
      go(8'h0A, 8'hFF, 3, -1);
      rd(9'h1FF, 1, -1);
      chk(u_ssee_host.rx[2], 8'hA9);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock, sequence, watchdog and verdict
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      nrst        = 1'b0;
      wp_n        = 1'b1;
      n_fail      = 0;
      comparisons = 0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_power_up;
      t_latch;
      t_page;
      t_protect;
      t_wp_drop;
      end_sim;
   end
   initial begin
      repeat (95000) @(posedge sys_clk);
      n_fail++;
      end_sim;
   end
   task end_sim;
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
endmodule // ssee_top_bench

`default_nettype wire

// >>> verilog/ssee_defs.vh
`ifndef SSEE_DEFS_VH
`define SSEE_DEFS_VH

// system clock period and write-cycle time
`define SSEE_CLK_NS        10
`define SSEE_TWC_NS        10000000

// array geometry
`define SSEE_ADDR_W        9
`define SSEE_PAGE_W        3

// opcode fields: upper nibble must be zero, bit 3 is address bit 8 or don't-care
`define SSEE_OPC_HI_MSB    7
`define SSEE_OPC_HI_LSB    4
`define SSEE_OPC_A8_BIT    3
`define SSEE_OPC_LO_MSB    2
`define SSEE_OPC_LO_LSB    0
`define SSEE_OP_SET_WL     3'h6
`define SSEE_OP_CLR_WL     3'h4
`define SSEE_OP_STAT_RD    3'h5
`define SSEE_OP_STAT_WR    3'h1
`define SSEE_OP_ARR_RD     3'h3
`define SSEE_OP_ARR_WR     3'h2

// status byte layout
`define SSEE_ST_BUSY_BIT   0
`define SSEE_ST_WEL_BIT    1
`define SSEE_ST_BP_LSB     2
`define SSEE_ST_BP_MSB     3
`define SSEE_ST_BUSY_VAL   8'hFF

// protect levels
`define SSEE_BP_NONE       2'h0
`define SSEE_BP_QUARTER    2'h1
`define SSEE_BP_HALF       2'h2
`define SSEE_BP_ALL        2'h3
`define SSEE_BP_RESET      2'h0

`endif

// >>> verilog/ssee_mem.v
`timescale 1ns/100ps
`default_nettype none
`include "ssee_defs.vh"

// byte array with one write port and one registered read port
module ssee_mem (
   input  wire                      sys_clk,
   input  wire                      wr_en,
   input  wire [`SSEE_ADDR_W-1:0]   wr_addr,
   input  wire [7:0]                wr_data,
   input  wire [`SSEE_ADDR_W-1:0]   rd_addr,
   output reg  [7:0]                rd_data
);

   reg [7:0] cells [0:(1<<`SSEE_ADDR_W)-1];

   // cells carry no reset, they model nonvolatile storage
   always @(posedge sys_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
   end

endmodule // ssee_mem
`default_nettype wire

// >>> verilog/ssee_sync.v
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser, one chain per bit
module ssee_sync #(
   parameter integer       W         = 1,
   parameter [W-1:0]       RESET_VAL = {W{1'b0}}
) (
   input  wire             sys_clk,
   input  wire             nrst,
   input  wire [W-1:0]     async_in,
   output wire [W-1:0]     sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_reg;
         reg stable_reg;
         // first stage feeds only the second
         always @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               meta_reg   <= RESET_VAL[i];
               stable_reg <= RESET_VAL[i];
            end else begin
               meta_reg   <= async_in[i];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stable_reg;
      end
   endgenerate

endmodule // ssee_sync
`default_nettype wire

// >>> verilog/ssee_top.v
`timescale 1ns/100ps
`default_nettype none
`include "ssee_defs.vh"

module ssee_top #(
   parameter integer WC_CYCLES = `SSEE_TWC_NS / `SSEE_CLK_NS
) (
   input  wire       sys_clk,
   input  wire       nrst,
   input  wire       cs_n,
   input  wire       sck,
   input  wire       si,
   input  wire       hold_n,
   input  wire       wp_n,
   output reg        so_out,
   output reg        so_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // constants and states

   localparam [31:0] WC_LAST  = WC_CYCLES - 1;
   localparam [7:0]  ST_IDLE  = 8'h01;
   localparam [7:0]  ST_OPC   = 8'h02;
   localparam [7:0]  ST_ADDR  = 8'h04;
   localparam [7:0]  ST_RDATA = 8'h08;
   localparam [7:0]  ST_STAT  = 8'h10;
   localparam [7:0]  ST_WDATA = 8'h20;
   localparam [7:0]  ST_WSR   = 8'h40;
   localparam [7:0]  ST_DEAD  = 8'h80;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection

   wire [4:0] pins_s;
   wire       cs_n_s;
   wire       sck_s;
   wire       si_s;
   wire       hold_n_s;
   wire       wp_n_s;
   reg        sck_d_reg;
   reg        cs_n_d_reg;

   ssee_sync #(
      .W         (5),
      .RESET_VAL (5'h19)
   ) u_sync (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in ({wp_n, hold_n, si, sck, cs_n}),
      .sync_out (pins_s)
   );

   assign cs_n_s   = pins_s[0];
   assign sck_s    = pins_s[1];
   assign si_s     = pins_s[2];
   assign hold_n_s = pins_s[3];
   assign wp_n_s   = pins_s[4];

   // delayed copies for edge detection
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sck_d_reg  <= 1'b0;
         cs_n_d_reg <= 1'b1;
      end else begin
         sck_d_reg  <= sck_s;
         cs_n_d_reg <= cs_n_s;
      end
   end

   wire sck_rise = sck_s & ~sck_d_reg;
   wire sck_fall = ~sck_s & sck_d_reg;
   wire cs_fall  = ~cs_n_s & cs_n_d_reg;
   wire cs_rise  = cs_n_s & ~cs_n_d_reg;
   wire paused   = ~hold_n_s;

   ////////////////////////////////////////////////////////////////////////////////
   // state registers

   reg [7:0]                state_reg,    state_next;
   reg [2:0]                bcnt_reg,     bcnt_next;
   reg [7:0]                sh_reg,       sh_next;
   reg [`SSEE_ADDR_W-1:0]   addr_reg,     addr_next;
   reg                      is_wr_reg,    is_wr_next;
   reg                      wel_reg,      wel_next;
   reg [1:0]                bp_reg,       bp_next;
   reg [1:0]                new_bp_reg,   new_bp_next;
   reg                      sr_got_reg,   sr_got_next;
   reg [7:0]                pvld_reg,     pvld_next;
   reg [7:0]                osh_reg,      osh_next;
   reg [2:0]                ocnt_reg,     ocnt_next;
   reg                      so_next;
   reg                      oe_next;
   reg                      busy_reg,     busy_next;
   reg                      prog_sr_reg,  prog_sr_next;
   reg [19:0]               tmr_reg,      tmr_next;
   reg [3:0]                pidx_reg,     pidx_next;
   reg                      pbuf_we;
   reg [7:0]                pbuf [0:7];

   wire [7:0]               byte_in = {sh_reg[6:0], si_s};
   wire [7:0]               rd_data;
   wire [7:0]               status_byte;
   wire [`SSEE_ADDR_W-1:0]  prog_addr = {addr_reg[8:3], pidx_reg[2:0]};
   wire                     prog_prot;
   wire                     mem_we;

   ////////////////////////////////////////////////////////////////////////////////
   // status byte and protection

   // idle: upper nibble zero, protect bits, latch, ready; busy: all ones
   assign status_byte = busy_reg ? `SSEE_ST_BUSY_VAL
                                 : {4'h0, bp_reg, wel_reg, 1'b0};

   // region selected by the protect bits
   function prot_hit;
      input [1:0]              lvl;
      input [`SSEE_ADDR_W-1:0] a;
      begin
         case (lvl)
            `SSEE_BP_QUARTER: prot_hit = (a[8:7] == 2'h3);
            `SSEE_BP_HALF:    prot_hit = a[8];
            `SSEE_BP_ALL:     prot_hit = 1'b1;
            default:          prot_hit = 1'b0;
         endcase
      end
   endfunction

   assign prog_prot = prot_hit(bp_reg, prog_addr);
   // one page entry per clock at the start of the cycle, skipping protected bytes
   assign mem_we = busy_reg & ~prog_sr_reg & ~pidx_reg[3]
                 & pvld_reg[pidx_reg[2:0]] & ~prog_prot;

   ssee_mem u_mem (
      .sys_clk (sys_clk),
      .wr_en   (mem_we),
      .wr_addr (prog_addr),
      .wr_data (pbuf[pidx_reg[2:0]]),
      .rd_addr (addr_reg),
      .rd_data (rd_data)
   );

   // page buffer collects bytes until select rises
   always @(posedge sys_clk) begin
      if (pbuf_we) begin
         pbuf[addr_reg[2:0]] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command sequencer

   always @* begin
      state_next   = state_reg;
      bcnt_next    = bcnt_reg;
      sh_next      = sh_reg;
      addr_next    = addr_reg;
      is_wr_next   = is_wr_reg;
      wel_next     = wel_reg;
      bp_next      = bp_reg;
      new_bp_next  = new_bp_reg;
      sr_got_next  = sr_got_reg;
      pvld_next    = pvld_reg;
      osh_next     = osh_reg;
      ocnt_next    = ocnt_reg;
      so_next      = so_out;
      busy_next    = busy_reg;
      prog_sr_next = prog_sr_reg;
      tmr_next     = tmr_reg;
      pidx_next    = pidx_reg;
      pbuf_we      = 1'b0;

      // internal cycle runs on regardless of the link
      if (busy_reg) begin
         tmr_next = tmr_reg + 20'h0_0001;
         if (!pidx_reg[3]) begin
            pidx_next = pidx_reg + 4'h1;
         end
         if (tmr_reg == WC_LAST[19:0]) begin
            busy_next = 1'b0;
            wel_next  = 1'b0;
            if (prog_sr_reg) begin
               bp_next = new_bp_reg;
            end
         end
      end

      if (cs_fall) begin
         // new frame: fresh opcode capture
         state_next  = ST_OPC;
         bcnt_next   = 3'h0;
         ocnt_next   = 3'h0;
         sr_got_next = 1'b0;
         pvld_next   = 8'h00;
      end else if (cs_n_s) begin
         // deselected: nothing accepted, output floats
         state_next = ST_IDLE;
         if (cs_rise && bcnt_reg == 3'h0 && wel_reg && wp_n_s && !busy_reg) begin
            if (state_reg == ST_WDATA && pvld_reg != 8'h00) begin
               busy_next    = 1'b1;
               prog_sr_next = 1'b0;
               tmr_next     = 20'h0_0000;
               pidx_next    = 4'h0;
            end else if (state_reg == ST_WSR && sr_got_reg) begin
               busy_next    = 1'b1;
               prog_sr_next = 1'b1;
               tmr_next     = 20'h0_0000;
               pidx_next    = 4'h8;
            end
         end
      end else if (!paused) begin
         if (!wp_n_s && (state_reg == ST_WDATA || state_reg == ST_WSR)) begin
            state_next = ST_DEAD;
         end else if (sck_rise && (state_reg == ST_OPC || state_reg == ST_ADDR
                      || state_reg == ST_WDATA || state_reg == ST_WSR)) begin
            // msb first shift on rising clock
            sh_next   = byte_in;
            bcnt_next = bcnt_reg + 3'h1;
            if (bcnt_reg == 3'h7) begin
               case (state_reg)
                  ST_OPC: begin
                     if (byte_in[`SSEE_OPC_HI_MSB:`SSEE_OPC_HI_LSB] != 4'h0) begin
                        state_next = ST_DEAD;
                     end else if (busy_reg && byte_in[`SSEE_OPC_LO_MSB:`SSEE_OPC_LO_LSB]
                                  != `SSEE_OP_STAT_RD) begin
                        state_next = ST_DEAD;
                     end else begin
                        case (byte_in[`SSEE_OPC_LO_MSB:`SSEE_OPC_LO_LSB])
                           `SSEE_OP_SET_WL: begin
                              wel_next   = wp_n_s;
                              state_next = ST_DEAD;
                           end
                           `SSEE_OP_CLR_WL: begin
                              wel_next   = 1'b0;
                              state_next = ST_DEAD;
                           end
                           `SSEE_OP_STAT_RD: begin
                              state_next = ST_STAT;
                           end
                           `SSEE_OP_STAT_WR: begin
                              state_next = ST_WSR;
                           end
                           `SSEE_OP_ARR_RD: begin
                              addr_next[8] = byte_in[`SSEE_OPC_A8_BIT];
                              is_wr_next   = 1'b0;
                              state_next   = ST_ADDR;
                           end
                           `SSEE_OP_ARR_WR: begin
                              addr_next[8] = byte_in[`SSEE_OPC_A8_BIT];
                              is_wr_next   = 1'b1;
                              state_next   = ST_ADDR;
                           end
                           default: begin
                              state_next = ST_DEAD;
                           end
                        endcase
                     end
                  end
                  ST_ADDR: begin
                     addr_next[7:0] = byte_in;
                     if (!is_wr_reg) begin
                        state_next = ST_RDATA;
                     end else if (!wel_reg || !wp_n_s) begin
                        state_next = ST_DEAD;
                     end else begin
                        state_next = ST_WDATA;
                     end
                  end
                  ST_WDATA: begin
                     pbuf_we                 = 1'b1;
                     pvld_next[addr_reg[2:0]] = 1'b1;
                     addr_next[2:0]          = addr_reg[2:0] + 3'h1;
                  end
                  ST_WSR: begin
                     new_bp_next = byte_in[`SSEE_ST_BP_MSB:`SSEE_ST_BP_LSB];
                     sr_got_next = 1'b1;
                  end
                  default: begin
                     state_next = ST_DEAD;
                  end
               endcase
            end
         end else if (sck_fall && (state_reg == ST_RDATA || state_reg == ST_STAT)) begin
            // output changes on falling clock, msb first
            ocnt_next = ocnt_reg + 3'h1;
            if (ocnt_reg == 3'h0) begin
               if (state_reg == ST_STAT) begin
                  so_next  = status_byte[7];
                  osh_next = {status_byte[6:0], 1'b0};
               end else begin
                  so_next  = rd_data[7];
                  osh_next = {rd_data[6:0], 1'b0};
               end
            end else begin
               so_next  = osh_reg[7];
               osh_next = {osh_reg[6:0], 1'b0};
            end
            if (ocnt_reg == 3'h7 && state_reg == ST_RDATA) begin
               addr_next = addr_reg + 9'h001;
            end
         end
      end

      // drive only while selected, unpaused and sending
      oe_next = ~cs_n_s & ~paused
              & (state_next == ST_RDATA || state_next == ST_STAT)
              & (ocnt_next != 3'h0 || ocnt_reg != 3'h0 || so_oe);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= ST_IDLE;
         bcnt_reg    <= 3'h0;
         sh_reg      <= 8'h00;
         addr_reg    <= 9'h000;
         is_wr_reg   <= 1'b0;
         wel_reg     <= 1'b0;
         bp_reg      <= `SSEE_BP_RESET;
         new_bp_reg  <= `SSEE_BP_NONE;
         sr_got_reg  <= 1'b0;
         pvld_reg    <= 8'h00;
         osh_reg     <= 8'h00;
         ocnt_reg    <= 3'h0;
         so_out      <= 1'b0;
         so_oe       <= 1'b0;
         busy_reg    <= 1'b0;
         prog_sr_reg <= 1'b0;
         tmr_reg     <= 20'h0_0000;
         pidx_reg    <= 4'h8;
      end else begin
         state_reg   <= state_next;
         bcnt_reg    <= bcnt_next;
         sh_reg      <= sh_next;
         addr_reg    <= addr_next;
         is_wr_reg   <= is_wr_next;
         wel_reg     <= wel_next;
         bp_reg      <= bp_next;
         new_bp_reg  <= new_bp_next;
         sr_got_reg  <= sr_got_next;
         pvld_reg    <= pvld_next;
         osh_reg     <= osh_next;
         ocnt_reg    <= ocnt_next;
         so_out      <= so_next;
         so_oe       <= oe_next;
         busy_reg    <= busy_next;
         prog_sr_reg <= prog_sr_next;
         tmr_reg     <= tmr_next;
         pidx_reg    <= pidx_next;
      end
   end

endmodule // ssee_top
`default_nettype wire
